//--- pkg/pfm_pkg.sv
package pfm_pkg;
   // ****************************************************
   // register offsets
   // ****************************************************
   localparam logic [7:0] OFS_LEVEL1_PASSWORD = 8'hb0;
   localparam logic [7:0] OFS_LEVEL2_PASSWORD = 8'hb4;
   localparam logic [7:0] OFS_FAULT_GATE_MASK_SLOW = 8'hb8;
   localparam logic [7:0] OFS_FAULT_GATE_MASK_FAST = 8'hb9;
   localparam logic [7:0] OFS_TX_FAULT_MASK_SLOW = 8'hba;
   // ****************************************************
   // reset and read-back values
   // ****************************************************
   localparam logic [31:0] RST_PASSWORD = 32'hffff_ffff;
   localparam logic [31:0] RST_PASSWORD_ENTRY = 32'hffff_ffff;
   localparam logic [7:0] RST_MASK = 8'h00;
   localparam logic [7:0] READ_HIDDEN = 8'h00;
   localparam logic [7:0] READ_IDLE = 8'hff;
   // ****************************************************
   // field positions
   // ****************************************************
   // slow byte: temp, supply, mon1..mon4 from bit 7 downward
   localparam int SLOW_LSB = 2;
   // fast byte: power high, power low, bias high, bias max
   localparam int FAST_LSB = 4;
   localparam int BYTE_BITS = 8;
   // ****************************************************
   // serial port states
   // ****************************************************
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_PTR,
      ST_WR,
      ST_RD
   } pfm_state_t;
endpackage

//--- design/pfm_top.sv
`timescale 1ns/1ns
`default_nettype none
module pfm_top #(
   parameter logic [6:0] SLAVE_ADDR = 7'h2a, // arbitrary value
   parameter int SLOW_N = 6,
   parameter int FAST_N = 4
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // two-wire serial port, data line open drain
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   // password entry value from the entry register logic
   input wire logic pwe_load_i,
   input wire logic [31:0] password_entry_value_i,
   // alarm conditions
   input wire logic [SLOW_N-1:0] slow_alarm_i,
   input wire logic [FAST_N-1:0] fast_alarm_i,
   // access levels and fault pins
   output logic level1_access_o,
   output logic level2_access_o,
   output logic fast_fault_gate_pin_o,
   output logic tx_fault_o
);
   // ****************************************************
   // elaboration checks
   // ****************************************************
   if (SLOW_N + pfm_pkg::SLOW_LSB != pfm_pkg::BYTE_BITS) begin : g_bad_slow
      $error("slow alarm count must fill mask byte above reserved bits");
   end
   if (FAST_N + pfm_pkg::FAST_LSB != pfm_pkg::BYTE_BITS) begin : g_bad_fast
      $error("fast alarm count must fill mask byte above reserved bits");
   end

   // ****************************************************
   // pin synchronisers, change counts when stages 2 and 3 agree
   // ****************************************************
   logic [2:0] scl_sy, sda_sy;
   logic scl_f, sda_f;
   logic next_scl_f, next_sda_f;
   logic scl_rise, scl_fall, sda_rise, sda_fall;
   always_comb begin
      next_scl_f = (scl_sy[1] == scl_sy[2]) ? scl_sy[2] : scl_f;
      next_sda_f = (sda_sy[1] == sda_sy[2]) ? sda_sy[2] : sda_f;
      scl_rise = next_scl_f & ~scl_f;
      scl_fall = ~next_scl_f & scl_f;
      sda_rise = next_sda_f & ~sda_f;
      sda_fall = ~next_sda_f & sda_f;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         scl_sy <= 3'h7;
         sda_sy <= 3'h7;
         scl_f <= 1'b1;
         sda_f <= 1'b1;
      end else begin
         scl_sy <= {scl_sy[1:0], scl_i};
         sda_sy <= {sda_sy[1:0], sda_i};
         scl_f <= next_scl_f;
         sda_f <= next_sda_f;
      end
   end

   // ****************************************************
   // register state
   // ****************************************************
   logic [31:0] password_entry_value, pw1, pw2;
   logic [7:0] gate_slow, gate_fast, txf_slow;
   logic [31:0] next_pwe, next_pw1, next_pw2;
   logic [7:0] next_gate_slow, next_gate_fast, next_txf_slow;
   logic next_l1, next_l2, next_gate, next_txf;
   logic wr_stb;
   logic [7:0] wr_ptr, wr_data, rd_ptr, rd_byte;
   logic pw_hit, pw1_hit, pw2_hit;

   always_comb begin
      next_pwe = password_entry_value;
      next_pw1 = pw1;
      next_pw2 = pw2;
      next_gate_slow = gate_slow;
      next_gate_fast = gate_fast;
      next_txf_slow = txf_slow;
      if (pwe_load_i) begin
         next_pwe = password_entry_value_i;
      end
      pw1_hit = wr_ptr[7:2] == pfm_pkg::OFS_LEVEL1_PASSWORD[7:2];
      pw2_hit = wr_ptr[7:2] == pfm_pkg::OFS_LEVEL2_PASSWORD[7:2];
      // writes without level-2 are dropped silently
      if (wr_stb && level2_access_o) begin
         // lowest offset holds the most significant byte
         if (pw1_hit) begin
            next_pw1[{~wr_ptr[1:0], 3'b000} +: 8] = wr_data;
         end
         if (pw2_hit) begin
            next_pw2[{~wr_ptr[1:0], 3'b000} +: 8] = wr_data;
         end
         // reserved low bits are never stored
         if (wr_ptr == pfm_pkg::OFS_FAULT_GATE_MASK_SLOW) begin
            next_gate_slow = {wr_data[7:pfm_pkg::SLOW_LSB],
               pfm_pkg::SLOW_LSB'(0)};
         end
         if (wr_ptr == pfm_pkg::OFS_FAULT_GATE_MASK_FAST) begin
            next_gate_fast = {wr_data[7:pfm_pkg::FAST_LSB],
               pfm_pkg::FAST_LSB'(0)};
         end
         if (wr_ptr == pfm_pkg::OFS_TX_FAULT_MASK_SLOW) begin
            next_txf_slow = {wr_data[7:pfm_pkg::SLOW_LSB],
               pfm_pkg::SLOW_LSB'(0)};
         end
      end
      // compared every cycle so access tracks any change
      next_l1 = password_entry_value == pw1;
      next_l2 = password_entry_value == pw2;
      next_gate = |(slow_alarm_i & gate_slow[7:pfm_pkg::SLOW_LSB])
         | |(fast_alarm_i & gate_fast[7:pfm_pkg::FAST_LSB]);
      next_txf = |(slow_alarm_i & txf_slow[7:pfm_pkg::SLOW_LSB]);
      // password bytes are write only
      pw_hit = rd_ptr[7:3] == pfm_pkg::OFS_LEVEL1_PASSWORD[7:3];
      rd_byte = pfm_pkg::READ_HIDDEN;
      if (!pw_hit && level2_access_o) begin
         unique case (rd_ptr)
            pfm_pkg::OFS_FAULT_GATE_MASK_SLOW: rd_byte = gate_slow;
            pfm_pkg::OFS_FAULT_GATE_MASK_FAST: rd_byte = gate_fast;
            pfm_pkg::OFS_TX_FAULT_MASK_SLOW: rd_byte = txf_slow;
            default: rd_byte = pfm_pkg::READ_HIDDEN;
         endcase
      end
   end

   // nonvolatile contents are modelled as loaded with defaults at reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         password_entry_value <= pfm_pkg::RST_PASSWORD_ENTRY;
         pw1 <= pfm_pkg::RST_PASSWORD;
         pw2 <= pfm_pkg::RST_PASSWORD;
         gate_slow <= pfm_pkg::RST_MASK;
         gate_fast <= pfm_pkg::RST_MASK;
         txf_slow <= pfm_pkg::RST_MASK;
         level1_access_o <= 1'b0;
         level2_access_o <= 1'b0;
         fast_fault_gate_pin_o <= 1'b0;
         tx_fault_o <= 1'b0;
      end else begin
         password_entry_value <= next_pwe;
         pw1 <= next_pw1;
         pw2 <= next_pw2;
         gate_slow <= next_gate_slow;
         gate_fast <= next_gate_fast;
         txf_slow <= next_txf_slow;
         level1_access_o <= next_l1;
         level2_access_o <= next_l2;
         fast_fault_gate_pin_o <= next_gate;
         tx_fault_o <= next_txf;
      end
   end

   // ****************************************************
   // two-wire serial slave
   // ****************************************************
   pfm_pkg::pfm_state_t state, next_state;
   logic [3:0] cnt, next_cnt;
   logic [7:0] shin, next_shin, shout, next_shout, ptr, next_ptr;
   logic ack_ph, next_ack_ph, ack_drv, next_ack_drv;
   logic rw, next_rw, nack, next_nack, start, stop;

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_shin = shin;
      next_shout = shout;
      next_ptr = ptr;
      next_ack_ph = ack_ph;
      next_ack_drv = ack_drv;
      next_rw = rw;
      next_nack = nack;
      wr_stb = 1'b0;
      start = scl_f && next_scl_f && sda_fall;
      stop = scl_f && next_scl_f && sda_rise;
      if (start) begin
         next_state = pfm_pkg::ST_ADDR;
         next_cnt = 4'h0;
         next_ack_ph = 1'b0;
         next_ack_drv = 1'b0;
         next_shout = pfm_pkg::READ_IDLE;
      end else if (stop) begin
         next_state = pfm_pkg::ST_IDLE;
         next_ack_drv = 1'b0;
         next_shout = pfm_pkg::READ_IDLE;
      end else if (state != pfm_pkg::ST_IDLE && scl_rise) begin
         if (ack_ph) begin
            next_nack = sda_f;
         end else if (cnt < 4'h8) begin
            next_shin = {shin[6:0], sda_f};
            next_cnt = cnt + 4'h1;
         end
      end else if (state != pfm_pkg::ST_IDLE && scl_fall) begin
         if (!ack_ph && cnt == 4'h8) begin
            next_ack_ph = 1'b1;
            next_ack_drv = 1'b1;
            next_shout = pfm_pkg::READ_IDLE;
            unique case (state)
               pfm_pkg::ST_ADDR: begin
                  next_rw = shin[0];
                  if (shin[7:1] != SLAVE_ADDR) begin
                     next_state = pfm_pkg::ST_IDLE;
                     next_ack_drv = 1'b0;
                  end
               end
               pfm_pkg::ST_PTR: next_ptr = shin;
               pfm_pkg::ST_WR: begin
                  wr_stb = 1'b1;
                  next_ptr = ptr + 8'h01;
               end
               pfm_pkg::ST_RD: begin
                  next_ack_drv = 1'b0;
                  next_ptr = ptr + 8'h01;
               end
               default: next_state = pfm_pkg::ST_IDLE;
            endcase
         end else if (ack_ph) begin
            next_ack_ph = 1'b0;
            next_ack_drv = 1'b0;
            next_cnt = 4'h0;
            unique case (state)
               pfm_pkg::ST_ADDR: begin
                  next_state = rw ? pfm_pkg::ST_RD : pfm_pkg::ST_PTR;
                  if (rw) begin
                     next_shout = rd_byte;
                  end
               end
               pfm_pkg::ST_PTR: next_state = pfm_pkg::ST_WR;
               pfm_pkg::ST_WR: next_state = pfm_pkg::ST_WR;
               pfm_pkg::ST_RD: begin
                  if (nack) begin
                     next_state = pfm_pkg::ST_IDLE;
                  end else begin
                     next_shout = rd_byte;
                  end
               end
               default: next_state = pfm_pkg::ST_IDLE;
            endcase
         end else if (state == pfm_pkg::ST_RD && cnt != 4'h0) begin
            next_shout = {shout[6:0], 1'b1};
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= pfm_pkg::ST_IDLE;
         cnt <= 4'h0;
         shin <= 8'h00;
         shout <= pfm_pkg::READ_IDLE;
         ptr <= 8'h00;
         ack_ph <= 1'b0;
         ack_drv <= 1'b0;
         rw <= 1'b0;
         nack <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         shin <= next_shin;
         shout <= next_shout;
         ptr <= next_ptr;
         ack_ph <= next_ack_ph;
         ack_drv <= next_ack_drv;
         rw <= next_rw;
         nack <= next_nack;
      end
   end

   assign wr_ptr = ptr;
   assign wr_data = shin;
   assign rd_ptr = ptr;
   // open drain: only ever pulls low
   assign sda_o = 1'b0;
   assign sda_oe_n_o = ~(ack_drv
      || (state == pfm_pkg::ST_RD && !ack_ph && !shout[7]));

   // ****************************************************
   // checks
   // ****************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_locked_write;
      wr_stb && !level2_access_o;
   endsequence
   sequence s_entry_change;
      pwe_load_i ##1 !pwe_load_i;
   endsequence

   // the first edge after reset still shows the reset value of the flops
   chk_l1_match: assert property (!$past(rst_i) |->
      level1_access_o == ($past(password_entry_value) == $past(pw1)))
      else $error("level-1 access disagrees with compare");
   chk_l2_match: assert property (!$past(rst_i) |->
      level2_access_o == ($past(password_entry_value) == $past(pw2)))
      else $error("level-2 access disagrees with compare");
   chk_entry_reset: assert property (@(posedge clk_i) $fell(rst_i) |-> password_entry_value == 32'hffff_ffff)
      else $error("entry value not all ones after reset");
   chk_default_grant: assert property (@(posedge clk_i) $fell(rst_i) && !pwe_load_i |=> level1_access_o && level2_access_o)
      else $error("default passwords do not grant access");
   chk_pw_hidden: assert property (pw_hit |-> rd_byte == 8'h00)
      else $error("password byte read back nonzero");
   chk_pw_locked: assert property (s_locked_write |=> $stable(pw1) && $stable(pw2))
      else $error("password changed without level-2");
   chk_mask_locked: assert property (s_locked_write |=> $stable(gate_slow) && $stable(gate_fast) && $stable(txf_slow))
      else $error("mask changed without level-2");
   chk_mask_hidden: assert property (!level2_access_o |-> rd_byte == 8'h00)
      else $error("mask readable without level-2");
   chk_gate_or: assert property (fast_fault_gate_pin_o == |({$past(slow_alarm_i), $past(fast_alarm_i)} & {$past(gate_slow[7:2]), $past(gate_fast[7:4])}))
      else $error("fault gate pin not OR of masked alarms");
   chk_txf_or: assert property (tx_fault_o == |($past(slow_alarm_i) & $past(txf_slow[7:2])))
      else $error("tx fault pin not OR of masked alarms");
   chk_reserved_zero: assert property (gate_slow[1:0] == 2'h0 && gate_fast[3:0] == 4'h0 && txf_slow[1:0] == 2'h0)
      else $error("reserved mask bits not zero");
   // loaded value reaches the access output two edges after the strobe
   chk_entry_follow: assert property (s_entry_change |=>
      level1_access_o == ($past(password_entry_value_i, 2) == $past(pw1)))
      else $error("access did not follow new entry value");
endmodule
`default_nettype wire

//--- verif/pfm_host.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************
// two-wire host: drives scl, releases sda for ones
// ****************************************************
module pfm_host #(
   parameter logic [6:0] ADDR = 7'h2a,
   parameter int H = 8
) (
   // clock
   input wire logic clk_i,
   // resolved data line
   input wire logic sda_line_i,
   // pins, sda_o high means released
   output logic scl_o,
   output logic sda_o
);
   logic nak;
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
      nak = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // data moves two cycles after scl falls so the slave's
   // synchroniser sees the fall first
   task automatic clk_bit(input logic b, output logic s);
      tick(2);
      sda_o <= b;
      tick(H);
      scl_o <= 1'b1;
      tick(H);
      s = sda_line_i;
      scl_o <= 1'b0;
   endtask
   task automatic start_c;
      tick(2);
      sda_o <= 1'b1;
      tick(H);
      scl_o <= 1'b1;
      tick(H);
      sda_o <= 1'b0;
      tick(H);
      scl_o <= 1'b0;
   endtask
   task automatic stop_c;
      tick(2);
      sda_o <= 1'b0;
      tick(H);
      scl_o <= 1'b1;
      tick(H);
      sda_o <= 1'b1;
      tick(H);
   endtask
   task automatic byte_c(input logic [7:0] d, output logic [7:0] q,
                         output logic s);
      for (int i = 7; i >= 0; i--) begin
         clk_bit(d[i], q[i]);
      end
      clk_bit(1'b1, s);
   endtask
   task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
      logic [7:0] q;
      logic s;
      start_c;
      byte_c({ADDR, 1'b0}, q, s);
      nak = nak | s;
      byte_c(ofs, q, s);
      nak = nak | s;
      byte_c(d, q, s);
      nak = nak | s;
      stop_c;
   endtask
   // pointer write, repeated start, one byte read, master nack
   task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
      logic [7:0] q;
      logic s;
      start_c;
      byte_c({ADDR, 1'b0}, q, s);
      nak = nak | s;
      byte_c(ofs, q, s);
      nak = nak | s;
      start_c;
      byte_c({ADDR, 1'b1}, q, s);
      nak = nak | s;
      byte_c(8'hff, d, s);
      stop_c;
   endtask
endmodule
`default_nettype wire

//--- verif/pfm_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin \
   n_checks++; \
   if ((got) !== (exp)) begin \
      $display("unexpected %s expected %h seen %h", nm, exp, got); \
      n_errors++; \
   end \
end
module pfm_top_tb;
   logic clk_i, rst_i, pwe_load, l1, l2, gate, txf, sda_d, sda_oe_n;
   logic scl, sda_h;
   logic [31:0] password_entry_value;
   logic [5:0] slow;
   logic [3:0] fast;
   logic [7:0] rdat;
   wire logic sda_line;
   int n_errors = 0;
   int n_checks = 0;
   // open drain with pull-up: low if any party pulls low
   assign sda_line = sda_h & (sda_oe_n | sda_d);
   pfm_top i_pfm_top (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl),
      .sda_i(sda_line), .sda_o(sda_d), .sda_oe_n_o(sda_oe_n),
      .pwe_load_i(pwe_load), .password_entry_value_i(password_entry_value),
      .slow_alarm_i(slow), .fast_alarm_i(fast), .level1_access_o(l1),
      .level2_access_o(l2), .fast_fault_gate_pin_o(gate),
      .tx_fault_o(txf));
   pfm_host #(.ADDR(7'h2a)) i_pfm_host (.clk_i(clk_i),
      .sda_line_i(sda_line), .scl_o(scl), .sda_o(sda_h));
   // ****************************************************
   // helpers
   // ****************************************************
   task automatic final_report;
      if (n_errors == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic load_entry(input logic [31:0] v, input logic e1,
                             input logic e2);
      @(posedge clk_i);
      pwe_load <= 1'b1;
      password_entry_value <= v;
      @(posedge clk_i);
      pwe_load <= 1'b0;
      @(posedge clk_i);
      #1;
      `CHK("level1", e1, l1)
      `CHK("level2", e2, l2)
   endtask
   task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
      i_pfm_host.rd(ofs, rdat);
      `CHK("read data", exp, rdat)
   endtask
   task automatic slow_scan(input logic [7:0] gm, input logic [7:0] tm);
      for (int i = 0; i < 6; i++) begin
         @(posedge clk_i);
         slow <= 6'h20 >> i;
         @(posedge clk_i);
         #1;
         `CHK("gate slow", gm[7-i], gate)
         `CHK("tx fault", tm[7-i], txf)
      end
      @(posedge clk_i);
      slow <= 6'h00;
   endtask
   task automatic fast_scan(input logic [7:0] gm);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i);
         fast <= 4'h8 >> i;
         @(posedge clk_i);
         #1;
         `CHK("gate fast", gm[7-i], gate)
      end
      @(posedge clk_i);
      fast <= 4'h0;
   endtask
   // ****************************************************
   // scenarios
   // ****************************************************
   task automatic t_reset;
      repeat (2) @(posedge clk_i);
      #1;
      `CHK("level1", 1'b1, l1)
      `CHK("level2", 1'b1, l2)
      for (int i = 0; i < 8; i++) begin
         rd_chk(8'hb0 + 8'(i), 8'h00);
      end
      rd_chk(8'hb8, 8'h00);
      rd_chk(8'hb9, 8'h00);
      rd_chk(8'hba, 8'h00);
   endtask
   task automatic t_masks;
      i_pfm_host.wr(8'hb8, 8'hab);
      i_pfm_host.wr(8'hba, 8'h57);
      rd_chk(8'hb8, 8'ha8);
      rd_chk(8'hba, 8'h54);
      slow_scan(8'ha8, 8'h54);
      i_pfm_host.wr(8'hb8, 8'h54);
      i_pfm_host.wr(8'hba, 8'ha8);
      slow_scan(8'h54, 8'ha8);
      i_pfm_host.wr(8'hb9, 8'haf);
      rd_chk(8'hb9, 8'ha0);
      fast_scan(8'ha0);
      i_pfm_host.wr(8'hb9, 8'h5f);
      fast_scan(8'h50);
   endtask
   // writes without level 2 must leave masks and passwords alone
   task automatic t_lock;
      load_entry(32'h0000_0001, 1'b0, 1'b0);
      i_pfm_host.wr(8'hb8, 8'h00);
      i_pfm_host.wr(8'hb7, 8'h00);
      rd_chk(8'hb8, 8'h00);
      load_entry(32'hffff_ffff, 1'b1, 1'b1);
      rd_chk(8'hb8, 8'h54);
   endtask
   task automatic t_passwd;
      for (int i = 0; i < 4; i++) begin
         i_pfm_host.wr(8'hb0 + 8'(i), 8'h12 + 8'(i * 8'h22));
      end
      load_entry(32'h1234_5678, 1'b1, 1'b0);
      i_pfm_host.wr(8'hb7, 8'h3c);
      load_entry(32'hffff_ffff, 1'b0, 1'b1);
      i_pfm_host.wr(8'hb7, 8'h3c);
      load_entry(32'hffff_ff3c, 1'b0, 1'b1);
      rd_chk(8'hb7, 8'h00);
   endtask
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      rst_i = 1'b1;
      pwe_load = 1'b0;
      password_entry_value = 32'h0000_0000;
      slow = 6'h00;
      fast = 4'h0;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_masks;
      t_lock;
      t_passwd;
      `CHK("ack", 1'b0, i_pfm_host.nak)
      final_report;
   end
   initial begin
      repeat (100000) @(posedge clk_i);
      n_errors++;
      final_report;
   end
endmodule
`default_nettype wire
